// >>> src/mode_reg_pkg.sv
// Purpose: Shared constants and types for the peripheral mode-register bank
// Assumes: Register select is the low pointer nibble issued with each core command
// Notes:   Sequencer lengths are whole system clock cycles
package mode_reg_pkg;

	// ****************************************************************
	// Register and port selects (low pointer nibble)
	// ****************************************************************
	localparam logic [3:0] ADDR_PORT_ZERO      = 4'h0;
	localparam logic [3:0] ADDR_PORT_ONE       = 4'h1;
	localparam logic [3:0] ADDR_PORT_TWO       = 4'h2;
	localparam logic [3:0] ADDR_ANALOG_SELECT  = 4'h3;
	localparam logic [3:0] ADDR_PORT_FOUR      = 4'h4;
	localparam logic [3:0] ADDR_PORT_FIVE      = 4'h5;
	localparam logic [3:0] ADDR_CONV_CONTROL   = 4'h8;
	localparam logic [3:0] ADDR_CONV_HIGH      = 4'h9;
	localparam logic [3:0] ADDR_TIMER_COUNT    = 4'ha;
	localparam logic [3:0] ADDR_TIMER_RELOAD   = 4'hb;
	localparam logic [3:0] ADDR_TIMER_CONTROL  = 4'hc;
	localparam logic [3:0] ADDR_INT_MASK       = 4'he;
	localparam logic [3:0] ADDR_PORT_TWO_DIR   = 4'hf;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CC_LSB_HI     = 7;
	localparam int CC_LSB_LO     = 6;
	localparam int CC_POWER      = 5;
	localparam int CC_COMPARE    = 4;
	localparam int CC_START      = 3;
	localparam int CC_MODE       = 2;
	localparam int TC_RUN        = 3;
	localparam int IM_TIMER      = 2;
	localparam int IM_PIN1       = 1;
	localparam int IM_PIN0       = 0;
	localparam int FLAG_PIN0     = 0;
	localparam int FLAG_PIN1     = 1;
	localparam int FLAG_TIMER    = 2;

	// ****************************************************************
	// Reset values and encodings
	// ****************************************************************
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam logic [3:0] RESET_NIBBLE   = 4'h0;
	localparam logic [3:0] PORT_ZERO_IDLE = 4'hf;
	localparam logic [3:0] PIN_IDLE       = 4'hf;
	localparam logic [7:0] COUNT_MAX      = 8'hff;
	localparam logic [1:0] CLK_SYS        = 2'b00;
	localparam logic [1:0] CLK_DIV7       = 2'b01;
	localparam logic [1:0] CLK_DIV15      = 2'b10;
	localparam logic [1:0] CLK_EXT        = 2'b11;
	localparam logic [6:0] DIV7_ALL_ONES  = 7'h7f;
	localparam logic [14:0] DIV15_ALL_ONES = 15'h7fff;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int DATA_BITS          = 10;
	localparam int SYS_REF_PERIOD_NS  = 5000;
	localparam int CONV_TIME_NS       = 152500;
	localparam int COMP_TIME_NS       = 62500;
	localparam int CONV_CYCLES = (CONV_TIME_NS + SYS_REF_PERIOD_NS - 1) / SYS_REF_PERIOD_NS;
	localparam int COMP_CYCLES = (COMP_TIME_NS + SYS_REF_PERIOD_NS - 1) / SYS_REF_PERIOD_NS;
	localparam int SAR_STEP    = CONV_CYCLES / DATA_BITS;
	localparam logic [5:0] CONV_LAST     = 6'(CONV_CYCLES - 1);
	localparam logic [5:0] COMP_LAST     = 6'(COMP_CYCLES - 1);
	localparam logic [1:0] SAR_STEP_LAST = 2'(SAR_STEP - 1);
	localparam logic [3:0] SAR_TOP_BIT   = 4'(DATA_BITS - 1);
	localparam logic [9:0] DAC_MID       = 10'h200;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		OP_NONE        = 3'h0,
		OP_READ        = 3'h1,
		OP_WRITE       = 3'h2,
		OP_PORT_AND    = 3'h3,
		OP_PORT_OR     = 3'h4,
		OP_LATCH_WRITE = 3'h5
	} core_op_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_CONVERT = 3'b010,
		ST_COMPARE = 3'b100
	} conv_state_t;

	typedef struct packed {
		logic       valid;
		core_op_t   op;
		logic [3:0] addr;
		logic [3:0] second;
		logic [3:0] acc;
	} core_cmd_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] second;
		logic [3:0] acc;
	} read_reply_t;

endpackage : mode_reg_pkg

// >>> src/peripheral_mode_registers.sv
// Purpose: Converter, timer, mask, direction and port registers behind core I/O commands
// Assumes: Core commands and pins are synchronous to clk, the system clock
// Notes:   Analog front end lies outside; it returns one comparator level
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Conversion by successive approximation, result stored
// - Conversion lasts fixed count of system cycles
// - Comparison writes outcome into control bit four
// - Comparison lasts fixed count of system cycles
// - Register widths eight or four bits
// - Analog select bit makes pin analog input
// - Control bits seven, six hold result low bits
// - High data register holds upper eight bits
// - Power bit enables converter, cleared at end
// - Compare bit one when pin not below
// - Start bit set by software, cleared at end
// - Control bit two selects comparison mode
// - Control bits one, zero pick channel
// - Count reloads on overflow or write; read splits
// - Reload register written and read as nibbles
// - Timer control bit three runs timer
// - Timer control low bits pick count clock
// - Mask bits enable timer, pin one, pin zero
// - Direction bit makes port two pin output
// - Ports four, five follow last access direction
// - Pins two, three always release standby
// - Compare bit access has no side effect
// - Overflow and pin zero, pin one falling edges set flags
module peripheral_mode_registers (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire mode_reg_pkg::core_cmd_t   cmd,
	output var  mode_reg_pkg::read_reply_t reply,
	input  wire logic [2:0]                flag_clear,
	output var  logic [2:0]                request_flags,
	output var  logic [2:0]                irq_request,
	output var  logic                      standby_release,
	input  wire logic                      analog_above,
	output var  logic [9:0]                dac_code,
	output var  logic                      converter_power,
	output var  logic [1:0]                converter_channel,
	output var  logic [3:0]                analog_pin_enable,
	input  wire logic [3:0]                input_port_one,
	input  wire logic [3:0]                analog_input_port,
	output var  logic [3:0]                inverted_output_port,
	input  wire logic [3:0]                bidir_port_two_in,
	output var  logic [3:0]                bidir_port_two_out,
	output var  logic [3:0]                bidir_port_two_oe,
	input  wire logic [3:0]                bidir_port_four_in,
	output var  logic [3:0]                bidir_port_four_out,
	output var  logic                      bidir_port_four_oe,
	input  wire logic [3:0]                bidir_port_five_in,
	output var  logic [3:0]                bidir_port_five_out,
	output var  logic                      bidir_port_five_oe
);

	// ****************************************************************
	// Command decode
	// ****************************************************************
	mode_reg_pkg::conv_state_t state;
	logic [7:0]  converter_control;
	logic [7:0]  converter_high_data;
	logic [7:0]  timer_count;
	logic [7:0]  timer_reload;
	logic [3:0]  timer_control;
	logic [3:0]  interrupt_mask;
	logic [5:0]  seq_count;
	logic [1:0]  step_count;
	logic [3:0]  bit_index;
	logic [14:0] divider;
	logic [3:0]  pin_prev;
	logic [1:0]  pin_fall;
	logic [2:0]  next_flags;
	logic        count_tick;
	logic        overflow;
	logic       do_read;
	logic       do_write;
	logic       do_and;
	logic       do_or;
	logic [7:0] wr_byte;
	logic       ctrl_write;
	logic       start_op;
	logic       conv_end;
	logic       comp_end;
	logic       count_write;

	assign do_read     = cmd.valid && (cmd.op == mode_reg_pkg::OP_READ);
	assign do_write    = cmd.valid && (cmd.op == mode_reg_pkg::OP_WRITE);
	assign do_and      = cmd.valid && (cmd.op == mode_reg_pkg::OP_PORT_AND);
	assign do_or       = cmd.valid && (cmd.op == mode_reg_pkg::OP_PORT_OR);
	assign wr_byte     = {cmd.second, cmd.acc};
	assign ctrl_write  = do_write && (cmd.addr == mode_reg_pkg::ADDR_CONV_CONTROL);
	assign start_op    = ctrl_write && wr_byte[mode_reg_pkg::CC_START]
	                     && wr_byte[mode_reg_pkg::CC_POWER];
	assign conv_end    = state == mode_reg_pkg::ST_CONVERT && seq_count == mode_reg_pkg::CONV_LAST;
	assign comp_end    = state == mode_reg_pkg::ST_COMPARE && seq_count == mode_reg_pkg::COMP_LAST;
	assign count_write = do_write && (cmd.addr == mode_reg_pkg::ADDR_TIMER_COUNT);
	// ****************************************************************
	// Converter sequencer and its registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state               <= mode_reg_pkg::ST_IDLE;
			converter_control   <= mode_reg_pkg::RESET_BYTE;
			converter_high_data <= mode_reg_pkg::RESET_BYTE;
			dac_code            <= mode_reg_pkg::DAC_MID;
			seq_count           <= '0;
			step_count          <= '0;
			bit_index           <= mode_reg_pkg::SAR_TOP_BIT;
		end else begin
			if (do_write && (cmd.addr == mode_reg_pkg::ADDR_CONV_HIGH)) begin
				converter_high_data <= wr_byte;
			end
			case (state)
				mode_reg_pkg::ST_IDLE: begin
					seq_count <= '0;
				end
				mode_reg_pkg::ST_CONVERT: begin
					seq_count <= 6'(seq_count + 6'h1);
					if (step_count == mode_reg_pkg::SAR_STEP_LAST) begin
						step_count <= '0;
						if (!analog_above) begin
							dac_code[bit_index] <= 1'b0;
						end
						if (bit_index != 4'h0) begin
							dac_code[4'(bit_index - 4'h1)] <= 1'b1;
						end
						bit_index <= 4'(bit_index - 4'h1);
					end else begin
						step_count <= 2'(step_count + 2'h1);
					end
					if (conv_end) begin
						state                                 <= mode_reg_pkg::ST_IDLE;
						converter_high_data                   <= dac_code[9:2];
						converter_control[mode_reg_pkg::CC_LSB_HI:mode_reg_pkg::CC_LSB_LO]
						                                      <= dac_code[1:0];
						converter_control[mode_reg_pkg::CC_POWER] <= 1'b0;
						converter_control[mode_reg_pkg::CC_START] <= 1'b0;
					end
				end
				mode_reg_pkg::ST_COMPARE: begin
					seq_count <= 6'(seq_count + 6'h1);
					if (comp_end) begin
						state <= mode_reg_pkg::ST_IDLE;
						converter_control[mode_reg_pkg::CC_COMPARE] <= analog_above;
						converter_control[mode_reg_pkg::CC_POWER]   <= 1'b0;
						converter_control[mode_reg_pkg::CC_START]   <= 1'b0;
					end
				end
				default: begin
					state <= mode_reg_pkg::ST_IDLE;
				end
			endcase
			// Software write comes last so a start in the ending cycle is kept
			if (ctrl_write) begin
				converter_control[7:5] <= wr_byte[7:5];
				converter_control[2:0] <= wr_byte[2:0];
				converter_control[mode_reg_pkg::CC_START] <= start_op;
				seq_count  <= '0;
				step_count <= '0;
				bit_index  <= mode_reg_pkg::SAR_TOP_BIT;
				if (!start_op) begin
					state <= mode_reg_pkg::ST_IDLE;
				end else if (wr_byte[mode_reg_pkg::CC_MODE]) begin
					state    <= mode_reg_pkg::ST_COMPARE;
					dac_code <= {converter_high_data, wr_byte[7:6]};
				end else begin
					state    <= mode_reg_pkg::ST_CONVERT;
					dac_code <= mode_reg_pkg::DAC_MID;
				end
			end
		end
	end

	// ****************************************************************
	// Converter pin and power outputs
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_pin_enable <= mode_reg_pkg::RESET_NIBBLE;
			converter_power   <= 1'b0;
			converter_channel <= 2'b00;
		end else begin
			if (do_write && (cmd.addr == mode_reg_pkg::ADDR_ANALOG_SELECT)) begin
				analog_pin_enable <= cmd.acc;
			end
			converter_power   <= converter_control[mode_reg_pkg::CC_POWER];
			converter_channel <= converter_control[1:0];
		end
	end

	// ****************************************************************
	// Timer divider, clock select and counter
	// ****************************************************************
	always_comb begin
		case (timer_control[1:0])
			mode_reg_pkg::CLK_SYS:   count_tick = 1'b1;
			mode_reg_pkg::CLK_DIV7:  count_tick = (divider[6:0] == mode_reg_pkg::DIV7_ALL_ONES);
			mode_reg_pkg::CLK_DIV15: count_tick = (divider == mode_reg_pkg::DIV15_ALL_ONES);
			mode_reg_pkg::CLK_EXT:   count_tick = pin_fall[1];
			default:                 count_tick = 1'b0;
		endcase
	end

	assign overflow = timer_control[mode_reg_pkg::TC_RUN] && count_tick && !count_write
	                  && (timer_count == mode_reg_pkg::COUNT_MAX);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divider <= '0;
		end else begin
			divider <= 15'(divider + 15'h1);
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_count   <= mode_reg_pkg::RESET_BYTE;
			timer_reload  <= mode_reg_pkg::RESET_BYTE;
			timer_control <= mode_reg_pkg::RESET_NIBBLE;
		end else begin
			if (do_write && (cmd.addr == mode_reg_pkg::ADDR_TIMER_RELOAD)) begin
				timer_reload <= wr_byte;
			end
			if (do_write && (cmd.addr == mode_reg_pkg::ADDR_TIMER_CONTROL)) begin
				timer_control <= {cmd.acc[3], 1'b0, cmd.acc[1:0]};
			end
			if (count_write) begin
				timer_count <= timer_reload;
			end else if (overflow) begin
				timer_count <= timer_reload;
			end else if (timer_control[mode_reg_pkg::TC_RUN] && count_tick) begin
				timer_count <= 8'(timer_count + 8'h1);
			end
		end
	end

	// ****************************************************************
	// Pin edges, request flags and standby release
	// ****************************************************************
	genvar pin;
	generate
		for (pin = 0; pin < 2; pin++) begin : g_pin_edge
			assign pin_fall[pin] = pin_prev[pin] && !input_port_one[pin];
		end
	endgenerate
	always_comb begin
		// A new event wins over a clear in the same cycle
		next_flags = request_flags & ~flag_clear;
		next_flags[mode_reg_pkg::FLAG_PIN0]  = next_flags[mode_reg_pkg::FLAG_PIN0] | pin_fall[0];
		next_flags[mode_reg_pkg::FLAG_PIN1]  = next_flags[mode_reg_pkg::FLAG_PIN1] | pin_fall[1];
		next_flags[mode_reg_pkg::FLAG_TIMER] = next_flags[mode_reg_pkg::FLAG_TIMER] | overflow;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev        <= mode_reg_pkg::PIN_IDLE;
			request_flags   <= 3'b000;
			irq_request     <= 3'b000;
			interrupt_mask  <= mode_reg_pkg::RESET_NIBBLE;
			standby_release <= 1'b0;
		end else begin
			pin_prev      <= input_port_one;
			request_flags <= next_flags;
			if (do_write && (cmd.addr == mode_reg_pkg::ADDR_INT_MASK)) begin
				interrupt_mask <= {1'b0, cmd.acc[2:0]};
			end
			irq_request <= next_flags & interrupt_mask[2:0];
			standby_release <= !input_port_one[2] || !input_port_one[3]
			                   || (interrupt_mask[mode_reg_pkg::IM_PIN0] && !input_port_one[0])
			                   || (interrupt_mask[mode_reg_pkg::IM_PIN1] && !input_port_one[1])
			                   || (interrupt_mask[mode_reg_pkg::IM_TIMER]
			                       && next_flags[mode_reg_pkg::FLAG_TIMER]);
		end
	end

	// ****************************************************************
	// Port latches and directions
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inverted_output_port <= mode_reg_pkg::PORT_ZERO_IDLE;
			bidir_port_two_out   <= mode_reg_pkg::RESET_NIBBLE;
			bidir_port_two_oe    <= mode_reg_pkg::RESET_NIBBLE;
			bidir_port_four_out  <= mode_reg_pkg::RESET_NIBBLE;
			bidir_port_five_out  <= mode_reg_pkg::RESET_NIBBLE;
			bidir_port_four_oe   <= 1'b0;
			bidir_port_five_oe   <= 1'b0;
		end else begin
			if ((cmd.valid && (cmd.op == mode_reg_pkg::OP_LATCH_WRITE))
			    || (do_write && (cmd.addr == mode_reg_pkg::ADDR_PORT_ZERO))) begin
				inverted_output_port <= ~cmd.acc;
			end else if (do_and && (cmd.addr == mode_reg_pkg::ADDR_PORT_ZERO)) begin
				inverted_output_port <= ~(~inverted_output_port & cmd.acc);
			end else if (do_or && (cmd.addr == mode_reg_pkg::ADDR_PORT_ZERO)) begin
				inverted_output_port <= inverted_output_port & ~cmd.acc;
			end
			if (do_write && (cmd.addr == mode_reg_pkg::ADDR_PORT_TWO_DIR)) begin
				bidir_port_two_oe <= cmd.acc;
			end
			if (cmd.addr == mode_reg_pkg::ADDR_PORT_TWO) begin
				if (do_write) bidir_port_two_out <= cmd.acc;
				if (do_and)   bidir_port_two_out <= bidir_port_two_out & cmd.acc;
				if (do_or)    bidir_port_two_out <= bidir_port_two_out | cmd.acc;
			end
			if (cmd.addr == mode_reg_pkg::ADDR_PORT_FOUR) begin
				if (do_write) bidir_port_four_out <= cmd.acc;
				if (do_and)   bidir_port_four_out <= bidir_port_four_out & cmd.acc;
				if (do_or)    bidir_port_four_out <= bidir_port_four_out | cmd.acc;
				if (do_write || do_and || do_or) bidir_port_four_oe <= 1'b1;
				if (do_read)  bidir_port_four_oe <= 1'b0;
			end
			if (cmd.addr == mode_reg_pkg::ADDR_PORT_FIVE) begin
				if (do_write) bidir_port_five_out <= cmd.acc;
				if (do_and)   bidir_port_five_out <= bidir_port_five_out & cmd.acc;
				if (do_or)    bidir_port_five_out <= bidir_port_five_out | cmd.acc;
				if (do_write || do_and || do_or) bidir_port_five_oe <= 1'b1;
				if (do_read)  bidir_port_five_oe <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Read reply
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reply <= '0;
		end else begin
			reply.valid  <= do_read;
			reply.second <= 4'h0;
			reply.acc    <= 4'h0;
			if (do_read) begin
				case (cmd.addr)
					mode_reg_pkg::ADDR_PORT_ONE:      reply.acc <= input_port_one;
					mode_reg_pkg::ADDR_PORT_TWO:      reply.acc <= bidir_port_two_in;
					mode_reg_pkg::ADDR_ANALOG_SELECT: reply.acc <= analog_pin_enable;
					mode_reg_pkg::ADDR_PORT_FOUR:     reply.acc <= bidir_port_four_in;
					mode_reg_pkg::ADDR_PORT_FIVE:     reply.acc <= bidir_port_five_in;
					mode_reg_pkg::ADDR_CONV_CONTROL:  {reply.second, reply.acc} <= converter_control;
					mode_reg_pkg::ADDR_CONV_HIGH:     {reply.second, reply.acc} <= converter_high_data;
					mode_reg_pkg::ADDR_TIMER_COUNT:   {reply.second, reply.acc} <= timer_count;
					mode_reg_pkg::ADDR_TIMER_RELOAD:  {reply.second, reply.acc} <= timer_reload;
					mode_reg_pkg::ADDR_TIMER_CONTROL: reply.acc <= timer_control;
					mode_reg_pkg::ADDR_INT_MASK:      reply.acc <= interrupt_mask;
					mode_reg_pkg::ADDR_PORT_TWO_DIR:  reply.acc <= bidir_port_two_oe;
					default:                          reply.acc <= 4'h0;
				endcase
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_CONV_RESULT: assert property (@(posedge clk) disable iff (!rst_n)
		(conv_end && !ctrl_write) |=> ({converter_high_data, converter_control[7:6]} == $past(dac_code)))
		else $error("conversion result not stored");
	AST_CONV_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
		((state == mode_reg_pkg::ST_CONVERT) && ($past(state) == mode_reg_pkg::ST_CONVERT)
		 && !$past(ctrl_write)) |-> (seq_count == 6'($past(seq_count) + 6'h1)))
		else $error("conversion counter did not advance");
	AST_CONV_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
		((state == mode_reg_pkg::ST_CONVERT) && !ctrl_write ##1 (state == mode_reg_pkg::ST_IDLE))
		|-> ($past(seq_count) == mode_reg_pkg::CONV_LAST))
		else $error("conversion ended at the wrong cycle");
	AST_COMP_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
		((state == mode_reg_pkg::ST_COMPARE) && !ctrl_write ##1 (state == mode_reg_pkg::ST_IDLE))
		|-> ($past(seq_count) == mode_reg_pkg::COMP_LAST))
		else $error("comparison ended at the wrong cycle");
	AST_COMP_RESULT: assert property (@(posedge clk) disable iff (!rst_n)
		(comp_end && !ctrl_write) |=> (converter_control[mode_reg_pkg::CC_COMPARE]
		== $past(analog_above)) && !converter_control[mode_reg_pkg::CC_START]
		&& !converter_control[mode_reg_pkg::CC_POWER])
		else $error("comparison outcome or end flags wrong");
	AST_BUSY_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		(state != mode_reg_pkg::ST_IDLE) |-> converter_control[mode_reg_pkg::CC_START])
		else $error("start bit low while operation runs");
	AST_COUNT_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
		(count_write || overflow) |=> (timer_count == $past(timer_reload)))
		else $error("count not reloaded");
	AST_OVERFLOW_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		overflow |=> request_flags[mode_reg_pkg::FLAG_TIMER])
		else $error("overflow did not set timer flag");
	AST_TIMER_STOP: assert property (@(posedge clk) disable iff (!rst_n)
		(!timer_control[mode_reg_pkg::TC_RUN] && !count_write) |=> $stable(timer_count))
		else $error("stopped timer moved");
	AST_PORT_FOUR_DIR: assert property (@(posedge clk) disable iff (!rst_n)
		(do_read && cmd.addr == mode_reg_pkg::ADDR_PORT_FOUR) |=> !bidir_port_four_oe ##1 1'b1)
		else $error("port four not input after read");

endmodule : peripheral_mode_registers

`default_nettype wire

// >>> testbench/analog_source.sv
// Purpose: Comparator seen by the converter
// Assumes: One pin level, set by the bench
// Notes:   Answers in the same cycle
`timescale 1ns/1ns
`default_nettype none
module analog_source (
	input  wire logic [9:0] level,
	input  wire logic [9:0] dac_code,
	output var  logic       analog_above
);
	always_comb analog_above = (level >= dac_code);
endmodule : analog_source
`default_nettype wire

// >>> testbench/peripheral_mode_registers_tb.sv
// Purpose: Register bank tests through core commands
// Assumes: Inputs change at the falling edge
// Notes:   Converter driven by a fixed pin level
`timescale 1ns/1ns
`default_nettype none
module peripheral_mode_registers_tb;
	logic clk = 1'b0, rst_n = 1'b0, above, p4oe, p5oe, sb, pw;
	logic [1:0] ch;
	mode_reg_pkg::core_cmd_t cmd = '0;
	mode_reg_pkg::read_reply_t reply;
	logic [2:0] flag_clear = 3'h0, flags, irq;
	logic [3:0] p1 = 4'hf, ip0, ana, p2o, p2oe, p4o, p5o;
	logic [9:0] dac, level = 10'h2a5, r;
	int error_cnt = 0, comparisons = 0;
	initial forever #25 clk = ~clk;
	analog_source i_src (.level(level), .dac_code(dac), .analog_above(above));
	peripheral_mode_registers i_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .reply(reply),
		.flag_clear(flag_clear), .request_flags(flags), .irq_request(irq),
		.standby_release(sb), .analog_above(above), .dac_code(dac), .converter_power(pw),
		.converter_channel(ch), .analog_pin_enable(ana), .input_port_one(p1),
		.analog_input_port(4'h0), .inverted_output_port(ip0), .bidir_port_two_in(4'h0),
		.bidir_port_two_out(p2o), .bidir_port_two_oe(p2oe), .bidir_port_four_in(4'h0),
		.bidir_port_four_out(p4o), .bidir_port_four_oe(p4oe), .bidir_port_five_in(4'h0),
		.bidir_port_five_out(p5o), .bidir_port_five_oe(p5oe));
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [3:0] a, logic [7:0] d,
		mode_reg_pkg::core_op_t op = mode_reg_pkg::OP_WRITE);
		@(negedge clk);
		cmd = {1'b1, op, a, d};
		@(negedge clk);
		cmd.valid = 1'b0;
	endtask : wr
	task automatic rd(logic [3:0] a, logic [7:0] e, string nm);
		wr(a, 8'h00, mode_reg_pkg::OP_READ);
		chk(nm, {reply.second, reply.acc}, e);
		chk("reply valid", {7'h0, reply.valid}, 8'h01);
	endtask : rd
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk("port zero", {4'h0, ip0}, 8'h0f);
		chk("port enables", {p2oe, 2'b00, p4oe, p5oe}, 8'h00);
		rd(4'h8, 8'h00, "conv ctl");
		$display("test reset done");
		wr(4'h3, 8'h05);
		chk("analog select", {4'h0, ana}, 8'h05);
		wr(4'hf, 8'h0a);
		chk("port two oe", {4'h0, p2oe}, 8'h0a);
		wr(4'he, 8'h0f);
		rd(4'he, 8'h07, "mask");
		wr(4'hc, 8'h04);
		rd(4'hc, 8'h00, "timer ctl");
		$display("test registers done");
		wr(4'hb, 8'hfe);
		wr(4'ha, 8'h00);
		rd(4'ha, 8'hfe, "count");
		rd(4'hb, 8'hfe, "reload");
		wr(4'hc, 8'h08);
		repeat (4) @(negedge clk);
		chk("timer flag", {5'h0, flags}, 8'h04);
		chk("timer irq", {5'h0, irq}, 8'h04);
		wr(4'hc, 8'h00);
		wr(4'ha, 8'h00);
		wr(4'hc, 8'h09);
		repeat (127) @(negedge clk);
		rd(4'ha, 8'hff, "div7 count");
		wr(4'hc, 8'h0b);
		wr(4'ha, 8'h00);
		p1 = 4'hd;
		@(negedge clk);
		p1 = 4'hf;
		rd(4'ha, 8'hff, "event count");
		chk("pin flags", {5'h0, flags}, 8'h06);
		chk("pin irq", {5'h0, irq}, 8'h06);
		flag_clear = 3'h7;
		p1 = 4'he;
		@(negedge clk);
		flag_clear = 3'h0;
		p1 = 4'hf;
		@(negedge clk);
		chk("flag clear", {5'h0, flags}, 8'h01);
		chk("no standby", {7'h0, sb}, 8'h00);
		$display("test timer done");
		wr(4'h8, 8'h2b);
		repeat (28) @(negedge clk);
		wr(4'h8, 8'h00, mode_reg_pkg::OP_READ);
		chk("busy", {7'h0, reply.acc[3]}, 8'h01);
		chk("power", {7'h0, pw}, 8'h01);
		chk("channel", {6'h0, ch}, 8'h03);
		rd(4'h9, level[9:2], "high data");
		rd(4'h8, {level[1:0], 6'h03}, "conv ctl");
		chk("power off", {7'h0, pw}, 8'h00);
		$display("test conversion done");
		for (int i = 0; i < 2; i++) begin
			r = level + 10'(i);
			wr(4'h9, r[9:2]);
			wr(4'h8, {r[1:0], 6'h2c});
			repeat (14) @(negedge clk);
			rd(4'h8, {r[1:0], 1'b0, i == 0, 4'h4}, "compare");
		end
		$display("test compare done");
		wr(4'h4, 8'h05);
		chk("port four oe", {3'h0, p4oe, p4o}, 8'h15);
		wr(4'h4, 8'h00, mode_reg_pkg::OP_READ);
		chk("port four in", {7'h0, p4oe}, 8'h00);
		wr(4'h5, 8'h03, mode_reg_pkg::OP_PORT_OR);
		wr(4'h5, 8'h02, mode_reg_pkg::OP_PORT_AND);
		chk("port five", {3'h0, p5oe, p5o}, 8'h12);
		wr(4'h2, 8'h09);
		wr(4'h2, 8'h0c, mode_reg_pkg::OP_PORT_OR);
		chk("port two out", {4'h0, p2o}, 8'h0d);
		wr(4'h0, 8'h03, mode_reg_pkg::OP_LATCH_WRITE);
		chk("port zero", {4'h0, ip0}, 8'h0c);
		p1 = 4'hb;
		repeat (2) @(negedge clk);
		chk("standby", {7'h0, sb}, 8'h01);
		$display("test ports done");
		end_sim();
	end
endmodule : peripheral_mode_registers_tb
`default_nettype wire
